// ---- pkg/imi_pkg.sv ----
// Shared constants, event indices and types for the two-wire master with events
package imi_pkg;
  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int CMD_W = 9;
  localparam int TXF_DEPTH = 4;
  localparam int RXF_DEPTH = 4;
  localparam int LVL_W = 3;
  localparam int CNT_W = 16;
  localparam int NEV = 12;
  // Command word field and abandon cause bit
  localparam int CMD_DIR_BIT = 8;
  localparam int ABN_SLVRD_BIT = 15;
  // Event bit positions in the status vectors
  localparam int EV_RX_UNDER = 0;
  localparam int EV_RX_OVER = 1;
  localparam int EV_RX_FULL = 2;
  localparam int EV_TX_OVER = 3;
  localparam int EV_TX_EMPTY = 4;
  localparam int EV_RD_REQ = 5;
  localparam int EV_TRANSMIT_ABANDON_FLAG = 6;
  localparam int EV_RX_DONE = 7;
  localparam int EV_ACTIVITY = 8;
  localparam int EV_STOP = 9;
  localparam int EV_START = 10;
  localparam int EV_GCALL = 11;
  // Values after reset
  localparam logic [CNT_W-1:0] HCNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] LCNT_RST = 16'h0000;
  localparam logic [NEV-1:0] MASK_RST = 12'h000;
  // Target modes
  localparam logic [1:0] TGT_NORMAL = 2'h0;
  localparam logic [1:0] TGT_GCALL = 2'h1;
  localparam logic [1:0] TGT_STARTB = 2'h2;
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [7:0] STARTB_VAL = 8'h01;
  localparam logic [4:0] TENBIT_HDR = 5'h1e;
  typedef enum logic [3:0] {
    IMI_IDLE, IMI_START, IMI_BIT, IMI_ACK, IMI_NEXT, IMI_STOP, IMI_HOLD
  } imi_state_e;
endpackage

// ---- pkg/imi_fifo_if.sv ----
// Valid/ready carrier between the main logic and its two-entry buffers
`timescale 1ns/1ps
interface imi_fifo_if #(parameter int W = 9);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic flush;
  logic [1:0] level;
  modport buf_side (input in_valid, in_data, out_ready, flush,
    output in_ready, out_valid, out_data, level);
  modport user_side (output in_valid, in_data, out_ready, flush,
    input in_ready, out_valid, out_data, level);
endinterface

// ---- logic/imi_buf2.sv ----
// Two-entry valid/ready buffer with flush and level
`timescale 1ns/1ps
module imi_buf2 #(
  parameter int W = 9
) (
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic ce_i, // Clock enable
  imi_fifo_if.buf_side f // Carrier
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0] cnt;
  } imi_buf_s;
  imi_buf_s st_reg, st_next;
  logic push, pop;

  // Handshakes come straight from the fill level
  assign f.in_ready = (st_reg.cnt != 2'd2);
  assign f.out_valid = (st_reg.cnt != 2'd0);
  assign f.out_data = st_reg.mem[0];
  assign f.level = st_reg.cnt;
  assign push = f.in_valid && f.in_ready;
  assign pop = f.out_valid && f.out_ready;

  // Shift register form keeps the head in slot 0
  always_comb begin
    st_next = st_reg;
    if (pop) begin
      st_next.mem[0] = st_reg.mem[1];
    end
    if (push) begin
      st_next.mem[st_reg.cnt - {1'b0, pop}] = f.in_data;
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
    if (f.flush) begin
      st_next.cnt = 2'd0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  a_buf_no_over: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st_reg.cnt <= 2'd2) else $error("buffer level above two");
endmodule // imi_buf2

// ---- logic/imi_sync3.sv ----
// Three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module imi_sync3 (
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic ce_i, // Clock enable
  input wire logic d_i, // Async input
  output logic q_o // Filtered level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } imi_sync_s;
  imi_sync_s st_reg, st_next;

  // First stage feeds only the second
  always_comb begin
    st_next = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= 4'hf;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end
  assign q_o = st_reg.q;
endmodule // imi_sync3

// ---- logic/imi_master.sv ----
// Two-wire bus master with command queue, event flags and mask
// What this block does
// - Disabled controller keeps both buffers empty
// - Enabled with queued command: START then address
// - Empty transmit queue ends with STOP
// - Command word: byte low, bit 8 read
// - Reads and writes mix freely in queue
// - Target holds 10-bit address, broadcast/start-byte mode
// - Master and slave address widths set independently
// - Read command during slave transmit is dropped
// - Conflict sets cause bit 15, abandon flag
// - Conflict raises read request; slave transmit busy holds clock low mid-transfer
// - Clock low/high for programmed cycle counts
// - Count writes taken only while disabled
// - Each event has its own mask bit
// - Raw and masked status both readable
// - Events cover bus, transfer and buffer conditions
// - Clear strobes clear one event, or all but activity
// - Buffer empty/full flags clear by hardware only
// - Activity clears by own strobe or idle-disabled
// - Combined event output feeds interrupt endpoint
// - Disable finishes current transfer, then flushes
`timescale 1ns/1ps
module imi_master
  import imi_pkg::*;
(
  input wire logic core_clk_i, // Clock, 100 MHz
  input wire logic rst_i, // Sync reset, active high
  input wire logic ce_i, // Clock enable
  input wire logic enable_i, // Controller enable
  input wire logic [9:0] remote_target_setting_i, // Target address
  input wire logic [1:0] target_mode_i, // Normal, broadcast, start byte
  input wire logic master_10bit_i, // Master uses 10-bit address
  input wire logic [9:0] own_slave_address_i, // Own slave address
  input wire logic slave_10bit_i, // Slave uses 10-bit address
  input wire logic slave_tx_busy_i, // Slave transmit in progress
  input wire logic [imi_pkg::CNT_W-1:0] clock_high_count_i, // High count
  input wire logic [imi_pkg::CNT_W-1:0] clock_low_count_i, // Low count
  input wire logic cmd_valid_i, // Command word strobe
  input wire logic [imi_pkg::CMD_W-1:0] cmd_data_i, // Command word
  output logic cmd_ready_o, // Command accepted
  output logic rx_valid_o, // Received byte available
  output logic [7:0] rx_data_o, // Received byte
  input wire logic rx_ready_i, // Receiver takes byte
  input wire logic [1:0] tx_threshold_i, // Transmit threshold level
  input wire logic [1:0] rx_threshold_i, // Receive threshold level
  input wire logic [imi_pkg::NEV-1:0] event_enable_bits_i, // Event mask
  input wire logic [imi_pkg::NEV-1:0] event_clear_i, // Per-event clear
  input wire logic global_event_clear_i, // Clear all events except activity
  output logic [imi_pkg::NEV-1:0] unmasked_event_status_o, // Raw events
  output logic [imi_pkg::NEV-1:0] masked_event_status_o, // Masked events
  output logic [15:0] abandon_cause_bits_o, // Abandon causes
  output logic enable_status_o, // Controller active status
  output logic event_o, // Combined event to endpoint
  input wire logic scl_i, // Serial clock line in
  output logic scl_o, // Serial clock line out
  output logic scl_oe_o, // Serial clock drive
  input wire logic sda_i, // Data line in
  output logic sda_o, // Data line out
  output logic sda_oe_o // Data line drive
);
  import imi_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    imi_state_e fsm;
    logic [CNT_W-1:0] hcnt;
    logic [CNT_W-1:0] lcnt;
    logic [CNT_W-1:0] tick;
    logic phase; // 0 low half, 1 high half
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic is_read;
    logic [1:0] addr_step;
    logic addr_done;
    logic en_act;
    logic nack;
    logic [NEV-1:0] raw;
    logic [15:0] cause;
    logic scl_drv;
    logic sda_drv;
    logic [7:0] rxb;
    logic rx_push;
  } imi_s;
  imi_s st_reg, st_next;

  logic scl_s, sda_s;
  imi_fifo_if #(.W(CMD_W)) txq ();
  imi_fifo_if #(.W(8)) rxq ();

  // ----------------------------------------------------------------
  // Pin sampling and buffers
  // ----------------------------------------------------------------
  imi_sync3 u_scl (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(scl_i), .q_o(scl_s));
  imi_sync3 u_sda (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(sda_i), .q_o(sda_s));
  imi_buf2 #(.W(CMD_W)) u_txq (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .f(txq.buf_side));
  imi_buf2 #(.W(8)) u_rxq (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .f(rxq.buf_side));

  logic conflict;
  logic tx_idle_flush;
  // A read command during slave transmit is swallowed, not queued
  assign conflict = cmd_valid_i && cmd_data_i[CMD_DIR_BIT] && slave_tx_busy_i;
  // Disabled controller: accept and drop commands, keep queues empty
  assign tx_idle_flush = !st_reg.en_act;
  assign txq.in_valid = cmd_valid_i && !conflict && st_reg.en_act;
  assign txq.in_data = cmd_data_i;
  assign txq.flush = tx_idle_flush;
  assign cmd_ready_o = !st_reg.en_act || conflict || txq.in_ready;
  assign rxq.in_valid = st_reg.rx_push;
  assign rxq.in_data = st_reg.rxb;
  assign rxq.flush = tx_idle_flush;
  assign rxq.out_ready = rx_ready_i;
  assign rx_valid_o = rxq.out_valid;
  assign rx_data_o = rxq.out_data;

  logic tick_done;
  logic [7:0] addr_byte;
  logic [NEV-1:0] set_ev, soft_clr;
  logic [1:0] rxlvl_next;
  assign tick_done = (st_reg.tick == '0);

  // Address phase bytes by target mode and addressing width
  always_comb begin
    addr_byte = {remote_target_setting_i[6:0], 1'b0};
    if (target_mode_i == TGT_GCALL) begin
      addr_byte = GCALL_ADDR;
    end else if (target_mode_i == TGT_STARTB) begin
      addr_byte = STARTB_VAL;
    end else if (master_10bit_i && st_reg.addr_step == 2'd0) begin
      addr_byte = {TENBIT_HDR, remote_target_setting_i[9:8], 1'b0};
    end else if (master_10bit_i) begin
      addr_byte = remote_target_setting_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rx_push = 1'b0;
    set_ev = '0;
    txq.out_ready = 1'b0;
    rxlvl_next = rxq.level;
    // Counts change only while the controller is held off
    if (!enable_i && !st_reg.en_act) begin
      st_next.hcnt = clock_high_count_i;
      st_next.lcnt = clock_low_count_i;
    end
    if (st_reg.tick != '0) begin
      st_next.tick = st_reg.tick - 16'h0001;
    end
    // Enable off takes effect only between transfers
    if (enable_i) begin
      st_next.en_act = 1'b1;
    end else if (st_reg.fsm == IMI_IDLE) begin
      st_next.en_act = 1'b0;
    end
    case (st_reg.fsm)
      IMI_IDLE: begin
        st_next.scl_drv = 1'b0;
        st_next.sda_drv = 1'b0;
        st_next.addr_done = 1'b0;
        st_next.addr_step = 2'd0;
        if (st_reg.en_act && enable_i && txq.out_valid) begin
          st_next.sda_drv = 1'b1;
          st_next.tick = st_reg.hcnt;
          st_next.fsm = IMI_START;
          set_ev[EV_START] = 1'b1;
          set_ev[EV_ACTIVITY] = 1'b1;
        end
      end
      IMI_START: begin
        if (tick_done) begin
          st_next.scl_drv = 1'b1;
          st_next.shreg = addr_byte | {7'h00, txq.out_data[CMD_DIR_BIT]
            & !master_10bit_i & (target_mode_i == TGT_NORMAL)};
          st_next.is_read = 1'b0;
          st_next.bitn = 4'd0;
          st_next.phase = 1'b0;
          st_next.tick = st_reg.lcnt;
          st_next.fsm = IMI_BIT;
        end
      end
      IMI_BIT, IMI_ACK: begin
        if (slave_tx_busy_i && st_reg.phase == 1'b0) begin
          st_next.fsm = IMI_HOLD;
        end else if (tick_done && st_reg.phase == 1'b0) begin
          st_next.scl_drv = 1'b0;
          st_next.phase = 1'b1;
          st_next.tick = st_reg.hcnt;
        end else if (tick_done && scl_s) begin
          st_next.scl_drv = 1'b1;
          st_next.phase = 1'b0;
          st_next.tick = st_reg.lcnt;
          if (st_reg.fsm == IMI_ACK) begin
            st_next.fsm = IMI_NEXT;
            st_next.nack = sda_s && !st_reg.is_read;
            if (st_reg.is_read) begin
              st_next.rx_push = 1'b1;
              st_next.rxb = st_reg.shreg;
              set_ev[EV_RX_OVER] = !rxq.in_ready;
              rxlvl_next = rxq.level + 2'd1;
            end
          end else begin
            if (st_reg.is_read) begin
              st_next.shreg = {st_reg.shreg[6:0], sda_s};
            end else begin
              st_next.shreg = {st_reg.shreg[6:0], 1'b0};
            end
            st_next.bitn = st_reg.bitn + 4'd1;
            if (st_reg.bitn == 4'd7) begin
              st_next.fsm = IMI_ACK;
            end
          end
        end
        // Set data in the low half, hold it through the high half; release for reads
        if (st_reg.fsm == IMI_BIT) begin
          st_next.sda_drv = !st_reg.is_read && !st_next.shreg[7];
        end else begin
          // Head was popped when this byte loaded: ACK only if more follow
          st_next.sda_drv = st_reg.is_read && txq.out_valid;
        end
        if (st_reg.fsm == IMI_BIT && st_next.fsm == IMI_BIT) begin
          st_next.sda_drv = st_reg.is_read ? 1'b0 : !st_reg.shreg[7];
        end
      end
      IMI_NEXT: begin
        if (st_reg.nack) begin
          set_ev[EV_TRANSMIT_ABANDON_FLAG] = 1'b1;
          st_next.fsm = IMI_STOP;
        end else if (!st_reg.addr_done && master_10bit_i
            && target_mode_i == TGT_NORMAL && st_reg.addr_step == 2'd0) begin
          st_next.addr_step = 2'd1;
          // Step is still 0 here, so the low byte is taken directly
          st_next.shreg = remote_target_setting_i[7:0];
          st_next.bitn = 4'd0;
          st_next.fsm = IMI_BIT;
        end else begin
          st_next.addr_done = 1'b1;
          // Pop each command as it loads, so the head is never the
          // byte just sent; STOP once the queue has run dry
          if (txq.out_valid) begin
            txq.out_ready = 1'b1;
            st_next.is_read = txq.out_data[CMD_DIR_BIT];
            st_next.shreg = txq.out_data[7:0];
            st_next.bitn = 4'd0;
            st_next.fsm = IMI_BIT;
          end else begin
            st_next.fsm = IMI_STOP;
          end
        end
        st_next.sda_drv = 1'b1;
        st_next.tick = st_reg.lcnt;
        st_next.phase = 1'b0;
      end
      IMI_STOP: begin
        if (tick_done && st_reg.scl_drv) begin
          st_next.scl_drv = 1'b0;
          st_next.tick = st_reg.hcnt;
        end else if (tick_done && scl_s) begin
          st_next.sda_drv = 1'b0;
          st_next.fsm = IMI_IDLE;
          // No pop here: a word queued during STOP must survive
          set_ev[EV_STOP] = 1'b1;
          st_next.nack = 1'b0;
        end
      end
      IMI_HOLD: begin
        st_next.scl_drv = 1'b1;
        if (!slave_tx_busy_i) begin
          st_next.fsm = IMI_BIT;
        end
      end
      default: begin
        st_next.fsm = IMI_IDLE;
      end
    endcase
    // Event sources; hardware set wins over any clear
    set_ev[EV_TRANSMIT_ABANDON_FLAG] = set_ev[EV_TRANSMIT_ABANDON_FLAG] | conflict;
    set_ev[EV_RD_REQ] = conflict;
    set_ev[EV_TX_OVER] = cmd_valid_i && st_reg.en_act && !conflict && !txq.in_ready;
    set_ev[EV_RX_UNDER] = rx_ready_i && !rxq.out_valid;
    set_ev[EV_GCALL] = st_reg.fsm == IMI_START && target_mode_i == TGT_GCALL;
    set_ev[EV_RX_DONE] = 1'b0;
    soft_clr = event_clear_i;
    if (global_event_clear_i) begin
      soft_clr = soft_clr | ~(NEV'(1) << EV_ACTIVITY);
    end
    st_next.raw = (st_reg.raw & ~soft_clr) | set_ev;
    // Level events follow the buffers directly
    st_next.raw[EV_TX_EMPTY] = (txq.level <= tx_threshold_i);
    st_next.raw[EV_RX_FULL] = (rxlvl_next > rx_threshold_i);
    if (!st_reg.en_act && st_reg.fsm == IMI_IDLE && scl_s && sda_s
        && !set_ev[EV_ACTIVITY]) begin
      st_next.raw[EV_ACTIVITY] = 1'b0;
    end
    st_next.cause = st_reg.cause;
    if (soft_clr[EV_TRANSMIT_ABANDON_FLAG]) begin
      st_next.cause = '0;
    end
    if (conflict) begin
      st_next.cause[ABN_SLVRD_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.hcnt <= HCNT_RST;
      st_reg.lcnt <= LCNT_RST;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: drive low only, enable while pulling
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = st_reg.scl_drv;
  assign sda_oe_o = st_reg.sda_drv;
  assign unmasked_event_status_o = st_reg.raw;
  assign masked_event_status_o = st_reg.raw & event_enable_bits_i;
  assign event_o = |(st_reg.raw & event_enable_bits_i);
  assign abandon_cause_bits_o = st_reg.cause;
  assign enable_status_o = st_reg.en_act;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_conflict_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && conflict |=> st_reg.raw[EV_TRANSMIT_ABANDON_FLAG] && st_reg.cause[ABN_SLVRD_BIT]
    && st_reg.raw[EV_RD_REQ]) else $error("conflict flags not set");
  a_conflict_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    conflict |-> !txq.in_valid) else $error("conflicting read queued");
  a_disabled_empty: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && !st_reg.en_act |=> txq.level == 2'd0 || st_reg.en_act)
    else $error("queue holds data while disabled");
  a_cnt_locked: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && st_reg.en_act |=> $stable(st_reg.hcnt) && $stable(st_reg.lcnt))
    else $error("count changed while enabled");
  a_mask_out: assert property (@(posedge core_clk_i) disable iff (rst_i)
    event_o == |masked_event_status_o) else $error("event output mismatch");
  a_start_begin: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && st_reg.fsm == IMI_IDLE && st_reg.en_act && enable_i && txq.out_valid
    |=> st_reg.sda_drv && !st_reg.scl_drv) else $error("no start issued");
  a_global_keep_act: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && global_event_clear_i && !event_clear_i[EV_ACTIVITY] && st_reg.raw[EV_ACTIVITY]
    && st_reg.en_act |=> st_reg.raw[EV_ACTIVITY]) else $error("activity lost");
  a_soft_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && global_event_clear_i && !set_ev[EV_STOP] |=> !st_reg.raw[EV_STOP])
    else $error("global clear ignored");
endmodule // imi_master

// ---- verification/imi_slave_model.sv ----
// Remote slave model: acks written bytes, answers reads with a fixed byte
`timescale 1ns/1ps
module imi_slave_model #(
  parameter logic [7:0] RD_BYTE = 8'h3c
) (
  input wire logic scl_i, // Bus clock level
  input wire logic sda_i, // Bus data level
  output logic sda_pull_o // High pulls data low
);
  logic [7:0] got [$];
  logic [7:0] sh = 8'h00;
  logic first = 1'b0;
  logic rd = 1'b0;
  logic xmit = 1'b0;
  int bitn = 0;
  int nstart = 0;
  int nstop = 0;
  initial sda_pull_o = 1'b0;
  // Start and stop are data edges while the clock is high
  always @(negedge sda_i) begin
    if (scl_i) begin
      bitn = 0;
      first = 1'b1;
      xmit = 1'b0;
      nstart++;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i) begin
      xmit = 1'b0;
      nstop++;
    end
  end
  // Sample on the rising clock; a master NACK ends our read answer
  always @(posedge scl_i) begin
    if (bitn < 8) sh = {sh[6:0], sda_i};
    else if (first) begin
      first = 1'b0;
      xmit = rd;
    end
    else if (xmit && sda_i) xmit = 1'b0;
    bitn = (bitn == 8) ? 0 : bitn + 1;
    if (bitn == 8 && !xmit) begin
      got.push_back(sh);
      if (first) rd = sh[0];
    end
  end
  // Set the drive on each falling clock; it holds through the high half
  always @(negedge scl_i) begin
    if (bitn == 8) sda_pull_o = !xmit;
    else sda_pull_o = xmit && !RD_BYTE[7 - bitn];
  end
endmodule // imi_slave_model

// ---- verification/testbench.sv ----
// Bench for the two-wire master: queue, bus bytes, events and buffers
`timescale 1ns/1ps
module testbench;
  import imi_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en = 1'b0;
  logic busy = 1'b0;
  logic m10 = 1'b0;
  logic [1:0] mode = TGT_NORMAL;
  logic [9:0] tgt = 10'h02b;
  logic [15:0] hcnt = 16'h0005;
  logic [15:0] lcnt = 16'h0005;
  logic cv = 1'b0;
  logic [8:0] cd = 9'h000;
  logic rxr = 1'b0;
  logic [11:0] mask = 12'h000;
  logic [11:0] clr = 12'h000;
  logic gclr = 1'b0;
  logic cr, rxv, ev, en_st, scl_oe, scl_o, sda_oe, sda_o, pull;
  logic [7:0] rxd;
  logic [11:0] raw, msk;
  logic [15:0] cause;
  logic [7:0] exp0 [3] = '{8'h56, GCALL_ADDR, {TENBIT_HDR, 3'h0}};
  int fails = 0;
  int total_checks = 0;
  int i, n0, len;
  // Open-drain lines with pull-ups
  wire scl = scl_oe ? scl_o : 1'b1;
  wire sda = (sda_oe ? sda_o : 1'b1) & !pull;
  // Core clock, 10 ns period
  always #5 core_clk_i = ~core_clk_i;
  imi_master imi_master_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1), .enable_i(en),
    .remote_target_setting_i(tgt), .target_mode_i(mode), .master_10bit_i(m10),
    .own_slave_address_i(10'h011), .slave_10bit_i(1'b0), .slave_tx_busy_i(busy),
    .clock_high_count_i(hcnt), .clock_low_count_i(lcnt), .cmd_valid_i(cv),
    .cmd_data_i(cd), .cmd_ready_o(cr), .rx_valid_o(rxv), .rx_data_o(rxd),
    .rx_ready_i(rxr), .tx_threshold_i(2'h0), .rx_threshold_i(2'h0),
    .event_enable_bits_i(mask), .event_clear_i(clr), .global_event_clear_i(gclr),
    .unmasked_event_status_o(raw), .masked_event_status_o(msk),
    .abandon_cause_bits_o(cause), .enable_status_o(en_st), .event_o(ev),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe));
  imi_slave_model slave_inst (.scl_i(scl), .sda_i(sda), .sda_pull_o(pull));
  // Compare, count and report
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A bound that runs out ends the run at once
  task automatic guard(input bit ok);
    if (!ok) begin
      fails++;
      complete_run;
    end
  endtask
  task automatic nc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // Hold the word until an edge sees ready high, then one idle edge
  task automatic put(input logic [8:0] w);
    cv = 1'b1;
    cd = w;
    for (i = 0; i < 5000 && cr !== 1'b1; i++) nc(1);
    guard(cr === 1'b1);
    nc(1);
    cv = 1'b0;
    nc(1);
  endtask
  // Length of the second clock-low drive seen from now
  task automatic meas(output int n);
    for (i = 0; i < 4; i++)
      for (n = 0; n < 3000 && scl_oe === i[0]; n++) nc(1);
    guard(n < 3000);
  endtask
  task automatic wait_stop;
    n0 = slave_inst.nstop;
    for (i = 0; i < 20000 && slave_inst.nstop == n0; i++) nc(1);
    guard(slave_inst.nstop > n0);
  endtask
  initial begin
    nc(10);
    rst_i = 1'b0;
    nc(2);
    check("tx_empty", raw[EV_TX_EMPTY], 1'b1);
    put(9'h0a5);
    en = 1'b1;
    nc(300);
    check("starts", 16'(slave_inst.nstart), 16'h0000);
    $display("test disabled_write done");
    lcnt = 16'h0009;
    for (int k = 0; k < 3; k++) begin
      mode = (k == 1) ? TGT_GCALL : TGT_NORMAL;
      m10 = (k == 2);
      slave_inst.got.delete();
      put(9'h0a5);
      meas(len);
      check("low_len", 16'(len), 16'h0006);
      wait_stop();
      check("addr", slave_inst.got[0], exp0[k]);
      check("data", slave_inst.got[$], 8'ha5);
      check("bytes", 16'(slave_inst.got.size()), (k == 2) ? 16'h0003 : 16'h0002);
    end
    $display("test write_modes done");
    mode = TGT_NORMAL;
    m10 = 1'b0;
    busy = 1'b1;
    mask = 12'h040;
    n0 = slave_inst.nstart;
    put(9'h100);
    nc(3);
    check("cause", cause[ABN_SLVRD_BIT], 1'b1);
    check("abandon", raw[EV_TRANSMIT_ABANDON_FLAG], 1'b1);
    check("read_req", raw[EV_RD_REQ], 1'b1);
    check("masked", msk, 12'h040);
    check("event", ev, 1'b1);
    check("starts", 16'(slave_inst.nstart), 16'(n0));
    busy = 1'b0;
    mask = 12'h000;
    clr = 12'h040;
    nc(1);
    clr = 12'h000;
    nc(1);
    check("event_off", ev, 1'b0);
    check("own_clear", raw[EV_TRANSMIT_ABANDON_FLAG:EV_RD_REQ], 2'h1);
    gclr = 1'b1;
    nc(1);
    gclr = 1'b0;
    nc(1);
    check("global_clear", raw[EV_ACTIVITY:EV_TX_EMPTY], 5'h11);
    en = 1'b0;
    for (i = 0; i < 1000 && en_st !== 1'b0; i++) nc(10);
    guard(en_st === 1'b0);
    nc(8);
    check("activity", raw[EV_ACTIVITY], 1'b0);
    $display("test conflict_events done");
    en = 1'b1;
    nc(2);
    slave_inst.got.delete();
    put(9'h05a);
    put(9'h1ff);
    put(9'h1ff);
    put(9'h077);
    check("full", cr, 1'b0);
    cv = 1'b1;
    nc(1);
    cv = 1'b0;
    nc(1);
    check("overflow", raw[EV_TX_OVER], 1'b1);
    meas(len);
    check("low_len", 16'(len), 16'h000a);
    for (i = 0; i < 20000 && slave_inst.got.size() < 5; i++) nc(1);
    guard(slave_inst.got.size() >= 5);
    wait_stop();
    check("mixed", {slave_inst.got[1], slave_inst.got[4]}, 16'h5a77);
    check("bytes", 16'(slave_inst.got.size()), 16'h0005);
    for (int k = 0; k < 2; k++) begin
      // Write-addressed transfer: nobody answers, the pull-up reads back
      check("rx", {rxv, rxd}, 16'h01ff);
      rxr = 1'b1;
      nc(1);
      rxr = 1'b0;
      nc(1);
    end
    check("rx_empty", rxv, 1'b0);
    rxr = 1'b1;
    nc(1);
    rxr = 1'b0;
    nc(1);
    check("rx_under", raw[EV_RX_UNDER], 1'b1);
    $display("test mixed_buffers done");
    slave_inst.got.delete();
    put(9'h1ff);
    wait_stop();
    check("rd_addr", slave_inst.got[0], 8'h57);
    check("rd_data", {rxv, rxd}, 16'h013c);
    $display("test read_answer done");
    complete_run;
  end
endmodule // testbench
